// ==== core/ppf_pad_ctrl.sv ====
// module: per-pin pad control, input synchroniser, noise filter and input gate
`timescale 1ns/1ps
`default_nettype none
module ppf_pad_ctrl #(
    parameter int N = 4,
    parameter ppf_pkg::ppf_pin_type_t PTYPE = ppf_pkg::TYPE_BIDIR_PLAIN
) (
    input wire logic mclk,
    input wire logic rst,
    ppf_pad_if.pad pif
);
    localparam logic [N-1:0] PULL_RST = {N{ppf_pkg::forced_on_in_reset(PTYPE)}};
    localparam logic [N-1:0] GATE_RST = {N{ppf_pkg::input_on_in_reset(PTYPE)}};
    localparam logic FILTER = ppf_pkg::has_noise_filter(PTYPE);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] flt;
        logic [N-1:0] gate;
        logic [N-1:0] pull;
        logic [N-1:0] oe;
        logic [N-1:0] out;
        logic [N-1:0] core;
    } ppf_pad_st_t;

    ppf_pad_st_t st;
    ppf_pad_st_t next_st;
    logic [N-1:0] drive;
    logic [N-1:0] val;
    logic [N-1:0] agree;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        // function output reaches the pin only with its own enable
        drive = (pif.cfgFunc & pif.cfgOut & pif.altOe) | (~pif.cfgFunc & pif.cfgOut);
        val = (pif.cfgFunc & pif.altOut) | (~pif.cfgFunc & pif.gpOut);
        next_st.out = val;
        // open drain only counts in function mode, it is don't-care otherwise
        next_st.oe = drive & ~(pif.cfgFunc & pif.cfgOd & val);
        next_st.pull = pif.cfgPull;
        next_st.gate = pif.cfgGate;
        next_st.s1 = pif.padIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // filtered type takes a new level only after two agreeing samples
        agree = FILTER ? ~(st.s2 ^ st.s3) : {N{1'b1}};
        next_st.flt = (agree & st.s2) | (~agree & st.flt);
        next_st.core = st.flt & st.gate;
    end

    // reset constants hold pull and gate in their forced state
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{s1: '0, s2: '0, s3: '0, flt: '0, gate: GATE_RST, pull: PULL_RST,
                oe: '0, out: '0, core: '0};
        end else begin
            st <= next_st;
        end
    end

    assign pif.padOut = st.out;
    assign pif.padOe = st.oe;
    assign pif.pullEn = st.pull;
    assign pif.coreIn = st.core;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_pull_follows: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) |-> pif.pullEn == $past(pif.cfgPull))
        else $error("pull enable does not follow its control bit");
    chk_gate_blocks: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst, 2) |-> pif.coreIn == ($past(st.flt) & $past(pif.cfgGate, 2)))
        else $error("input gate does not gate the core input");
    chk_reset_pull: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> $past(pif.pullEn) == PULL_RST)
        else $error("pull not forced to its reset state");
    chk_boot_gate: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> $past(st.gate) == GATE_RST)
        else $error("input gate not forced to its reset state");
    chk_func_oe: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) |-> (pif.padOe & $past(pif.cfgFunc) & ~$past(pif.altOe)) == '0)
        else $error("function pin driven without function enable");
    cov_func_drive: cover property (@(posedge mclk) disable iff (rst)
        |(pif.padOe & $past(pif.cfgFunc)));
endmodule
`default_nettype wire

// ==== core/ppf_pad_if.sv ====
// interface: configuration and pad signals between the register file and the pad logic
`timescale 1ns/1ps
`default_nettype none
interface ppf_pad_if #(parameter int N = 4);
    logic [N-1:0] cfgOut;
    logic [N-1:0] cfgFunc;
    logic [N-1:0] cfgOd;
    logic [N-1:0] cfgPull;
    logic [N-1:0] cfgGate;
    logic [N-1:0] gpOut;
    logic [N-1:0] altOut;
    logic [N-1:0] altOe;
    logic [N-1:0] padIn;
    logic [N-1:0] padOut;
    logic [N-1:0] padOe;
    logic [N-1:0] pullEn;
    logic [N-1:0] coreIn;

    modport ctl (output cfgOut, cfgFunc, cfgOd, cfgPull, cfgGate, gpOut, altOut, altOe, padIn,
        input padOut, padOe, pullEn, coreIn);
    modport pad (input cfgOut, cfgFunc, cfgOd, cfgPull, cfgGate, gpOut, altOut, altOe, padIn,
        output padOut, padOe, pullEn, coreIn);
endinterface
`default_nettype wire

// ==== core/ppf_pin_cfg.sv ====
// module: APB register file and pin configuration for the 4-bit and 8-bit ports
//
// Overview of operation
// - timer select bit 1 routes its pin to a timer capture; 3,2 timer six, 1,0 one
// - pull-up control bits 31..4 read zero, bits 3..0 read/write per pin
// - pull-up bit 1 enables pin pull-up, 0 disables it
// - input control bits 31..4 read zero, bits 3..0 read/write per pin
// - input control bit 1 passes pin input to core, 0 blocks it
// - pull forced off during reset for types marked forced-off
// - pull forced on during reset for both-pull bidirectional and output-only types
// - output-only type keeps input gate enabled during reset; synchroniser also held in reset, core input stays zero
// - function output drives pin only while the function asserts its enable
// - ten pin types differing in direction, analog, pulls, open drain, filter
// - every configuration bit resets to zero unless marked otherwise
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_cfg #(
    parameter ppf_pkg::ppf_pin_type_t K_TYPE = ppf_pkg::TYPE_FILTERED_IRQ,
    parameter ppf_pkg::ppf_pin_type_t A_TYPE = ppf_pkg::TYPE_BUS_ENFUNC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] kPadIn,
    output logic [3:0] kPullEn,
    output logic [3:0] kCoreIn,
    output logic timerOneCaptureA,
    output logic timerOneCaptureB,
    output logic timerSixCaptureA,
    output logic timerSixCaptureB,
    input wire logic [7:0] aPadIn,
    output logic [7:0] aPadOut,
    output logic [7:0] aPadOe,
    output logic [7:0] aPullEn,
    output logic [7:0] aCoreIn,
    input wire logic [7:0] aGpOut,
    input wire logic [7:0] extBusLineOut,
    input wire logic [7:0] extBusLineOe
);
    localparam int KP = ppf_pkg::K_PINS;
    localparam int AP = ppf_pkg::A_PINS;

    typedef struct packed {
        logic [KP-1:0] timerSel;
        logic [KP-1:0] pinPullupBits;
        logic [KP-1:0] pinInputGateBits;
        logic [AP-1:0] bytePortOutputCtrl;
        logic [AP-1:0] bytePortFuncSelect;
        logic [AP-1:0] bytePortOpenDrain;
        logic [AP-1:0] bytePortPullup;
        logic [AP-1:0] bytePortInputGate;
        logic [KP-1:0] timerCap;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } ppf_top_st_t;

    ppf_top_st_t st;
    ppf_top_st_t next_st;
    logic access;
    logic hit;
    logic [31:0] rmux;

    ppf_pad_if #(.N(KP)) kIf ();
    ppf_pad_if #(.N(AP)) aIf ();

    // ---------------------------------------------------------------
    // register read mux and decode
    // ---------------------------------------------------------------
    // unused upper bits are zero-extended, so nothing above the field reads back
    always_comb begin
        hit = 1'b1;
        rmux = ppf_pkg::RD_ZERO;
        case (paddr)
            ppf_pkg::OFF_TIMER_INPUT_SELECT: rmux = 32'(st.timerSel);
            ppf_pkg::OFF_PULLUP_CONTROL: rmux = 32'(st.pinPullupBits);
            ppf_pkg::OFF_INPUT_GATE_CONTROL: rmux = 32'(st.pinInputGateBits);
            ppf_pkg::OFF_BYTE_PORT_OUTPUT_CTRL: rmux = 32'(st.bytePortOutputCtrl);
            ppf_pkg::OFF_BYTE_PORT_FUNC_SELECT: rmux = 32'(st.bytePortFuncSelect);
            ppf_pkg::OFF_BYTE_PORT_OPEN_DRAIN: rmux = 32'(st.bytePortOpenDrain);
            ppf_pkg::OFF_BYTE_PORT_PULLUP: rmux = 32'(st.bytePortPullup);
            ppf_pkg::OFF_BYTE_PORT_INPUT_GATE: rmux = 32'(st.bytePortInputGate);
            ppf_pkg::OFF_PIN_LEVEL_STATUS: rmux = 32'({aIf.coreIn, kIf.coreIn});
            default: hit = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        access = psel && penable;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        next_st.rdata = ppf_pkg::RD_ZERO;
        // one wait state: answer is registered in the first access cycle and seen in the second
        if (access && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.err = !hit;
            next_st.rdata = pwrite ? ppf_pkg::RD_ZERO : rmux;
        end
        // writes land only at the completing edge; upper data bits are dropped
        if (access && st.ready && pwrite) begin
            case (paddr)
                ppf_pkg::OFF_TIMER_INPUT_SELECT: next_st.timerSel = pwdata[KP-1:0];
                ppf_pkg::OFF_PULLUP_CONTROL: next_st.pinPullupBits = pwdata[KP-1:0];
                ppf_pkg::OFF_INPUT_GATE_CONTROL: next_st.pinInputGateBits = pwdata[KP-1:0];
                ppf_pkg::OFF_BYTE_PORT_OUTPUT_CTRL: next_st.bytePortOutputCtrl = pwdata[AP-1:0];
                ppf_pkg::OFF_BYTE_PORT_FUNC_SELECT: next_st.bytePortFuncSelect = pwdata[AP-1:0];
                ppf_pkg::OFF_BYTE_PORT_OPEN_DRAIN: next_st.bytePortOpenDrain = pwdata[AP-1:0];
                ppf_pkg::OFF_BYTE_PORT_PULLUP: next_st.bytePortPullup = pwdata[AP-1:0];
                ppf_pkg::OFF_BYTE_PORT_INPUT_GATE: next_st.bytePortInputGate = pwdata[AP-1:0];
                default: next_st.err = 1'b0;
            endcase
        end
        // a pin routed to a timer keeps feeding the core input path too
        next_st.timerCap = kIf.coreIn & st.timerSel;
    end

    // all configuration resets to zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '{timerSel: ppf_pkg::RST_NIBBLE, pinPullupBits: ppf_pkg::RST_NIBBLE,
                pinInputGateBits: ppf_pkg::RST_NIBBLE, bytePortOutputCtrl: ppf_pkg::RST_BYTE,
                bytePortFuncSelect: ppf_pkg::RST_BYTE, bytePortOpenDrain: ppf_pkg::RST_BYTE,
                bytePortPullup: ppf_pkg::RST_BYTE, bytePortInputGate: ppf_pkg::RST_BYTE,
                timerCap: ppf_pkg::RST_NIBBLE, ready: 1'b0, err: 1'b0,
                rdata: ppf_pkg::RD_ZERO};
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // port wiring
    // ---------------------------------------------------------------
    // the 4-bit port has no output path in this block; its drive lives elsewhere
    assign kIf.cfgOut = '0;
    assign kIf.cfgFunc = '0;
    assign kIf.cfgOd = '0;
    assign kIf.cfgPull = st.pinPullupBits;
    assign kIf.cfgGate = st.pinInputGateBits;
    assign kIf.gpOut = '0;
    assign kIf.altOut = '0;
    assign kIf.altOe = '0;
    assign kIf.padIn = kPadIn;

    // single function select per pin is relied on: func bit 1 means bus line
    assign aIf.cfgOut = st.bytePortOutputCtrl;
    assign aIf.cfgFunc = st.bytePortFuncSelect;
    assign aIf.cfgOd = st.bytePortOpenDrain;
    assign aIf.cfgPull = st.bytePortPullup;
    assign aIf.cfgGate = st.bytePortInputGate;
    assign aIf.gpOut = aGpOut;
    assign aIf.altOut = extBusLineOut;
    assign aIf.altOe = extBusLineOe;
    assign aIf.padIn = aPadIn;

    ppf_pad_ctrl #(.N(KP), .PTYPE(K_TYPE)) kPad (
        .mclk(mclk),
        .rst(rst),
        .pif(kIf.pad)
    );

    ppf_pad_ctrl #(.N(AP), .PTYPE(A_TYPE)) aPad (
        .mclk(mclk),
        .rst(rst),
        .pif(aIf.pad)
    );

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign kPullEn = kIf.pullEn;
    assign kCoreIn = kIf.coreIn;
    assign timerOneCaptureA = st.timerCap[ppf_pkg::TIS_ONE_A];
    assign timerOneCaptureB = st.timerCap[ppf_pkg::TIS_ONE_B];
    assign timerSixCaptureA = st.timerCap[ppf_pkg::TIS_SIX_A];
    assign timerSixCaptureB = st.timerCap[ppf_pkg::TIS_SIX_B];
    assign aPadOut = aIf.padOut;
    assign aPadOe = aIf.padOe;
    assign aPullEn = aIf.pullEn;
    assign aCoreIn = aIf.coreIn;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_timer_route: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) |-> timerSixCaptureB == ($past(kIf.coreIn[3]) & $past(st.timerSel[3]))
            && timerOneCaptureA == ($past(kIf.coreIn[0]) & $past(st.timerSel[0])))
        else $error("timer capture routing wrong");
    chk_pullup_readzero: assert property (@(posedge mclk) disable iff (rst)
        (access && !pready && !pwrite && paddr == ppf_pkg::OFF_PULLUP_CONTROL)
            |=> pready && prdata == 32'($past(st.pinPullupBits)))
        else $error("pull-up control read wrong");
    chk_gate_readzero: assert property (@(posedge mclk) disable iff (rst)
        (access && !pready && !pwrite && paddr == ppf_pkg::OFF_INPUT_GATE_CONTROL)
            |=> prdata[31:4] == '0 && prdata[3:0] == $past(st.pinInputGateBits))
        else $error("input control read wrong");
    chk_write_masked: assert property (@(posedge mclk) disable iff (rst)
        (access && pready && pwrite && paddr == ppf_pkg::OFF_PULLUP_CONTROL)
            |=> st.pinPullupBits == $past(pwdata[3:0]) ##1 kPullEn == $past(pwdata[3:0], 2))
        else $error("pull-up write did not land in low bits only");
    chk_reset_zero: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> $past(st.timerSel) == '0 && $past(st.bytePortFuncSelect) == '0
            && $past(aPadOe) == '0)
        else $error("configuration not zero after reset");
    chk_unmapped_err: assert property (@(posedge mclk) disable iff (rst)
        (access && !pready && !hit) |=> pready && pslverr ##1 !pready && !pslverr)
        else $error("unmapped access not refused");
    cov_timer_write: cover property (@(posedge mclk) disable iff (rst)
        access && pready && pwrite && paddr == ppf_pkg::OFF_TIMER_INPUT_SELECT);
    cov_pull_read: cover property (@(posedge mclk) disable iff (rst)
        access && pready && !pwrite && paddr == ppf_pkg::OFF_PULLUP_CONTROL);
    cov_unmapped: cover property (@(posedge mclk) disable iff (rst) pready && pslverr);
    cov_capture: cover property (@(posedge mclk) disable iff (rst) timerOneCaptureA);
endmodule
`default_nettype wire

// ==== core/ppf_pkg.sv ====
// package: register map, reset values and pin types of the port pin configuration block
package ppf_pkg;
    localparam int K_PINS = 4;
    localparam int A_PINS = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [11:0] OFF_TIMER_INPUT_SELECT = 12'h010;
    localparam logic [11:0] OFF_PULLUP_CONTROL = 12'h02c;
    localparam logic [11:0] OFF_INPUT_GATE_CONTROL = 12'h038;
    localparam logic [11:0] OFF_BYTE_PORT_OUTPUT_CTRL = 12'h040;
    localparam logic [11:0] OFF_BYTE_PORT_FUNC_SELECT = 12'h044;
    localparam logic [11:0] OFF_BYTE_PORT_OPEN_DRAIN = 12'h048;
    localparam logic [11:0] OFF_BYTE_PORT_PULLUP = 12'h04c;
    localparam logic [11:0] OFF_BYTE_PORT_INPUT_GATE = 12'h050;
    localparam logic [11:0] OFF_PIN_LEVEL_STATUS = 12'h054;

    // -------------------------------------------------------------
    // reset values and field positions
    // -------------------------------------------------------------
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam int TIS_ONE_A = 0;
    localparam int TIS_ONE_B = 1;
    localparam int TIS_SIX_A = 2;
    localparam int TIS_SIX_B = 3;
    localparam int STAT_A_LSB = 4;

    // -------------------------------------------------------------
    // pin types
    // -------------------------------------------------------------
    typedef enum {
        TYPE_BIDIR_PLAIN,
        TYPE_BIDIR_PULLBOTH,
        TYPE_BIDIR_ENFUNC,
        TYPE_FILTERED_IRQ,
        TYPE_ANALOG_IN,
        TYPE_OUTPUT_ONLY,
        TYPE_BUS_ENFUNC,
        TYPE_BIDIR_INFUNC,
        TYPE_BIDIR_PULLDN,
        TYPE_BIDIR_PULLDN_EN
    } ppf_pin_type_t;

    // pull held on while reset stands, otherwise held off
    function automatic logic forced_on_in_reset(ppf_pin_type_t t);
        case (t)
            TYPE_BIDIR_PULLBOTH: forced_on_in_reset = 1'b1;
            TYPE_OUTPUT_ONLY: forced_on_in_reset = 1'b1;
            default: forced_on_in_reset = 1'b0;
        endcase
    endfunction

    // input gate held open during reset; the synchroniser is reset too, so no level is sampled
    function automatic logic input_on_in_reset(ppf_pin_type_t t);
        case (t)
            TYPE_OUTPUT_ONLY: input_on_in_reset = 1'b1;
            default: input_on_in_reset = 1'b0;
        endcase
    endfunction

    function automatic logic has_noise_filter(ppf_pin_type_t t);
        case (t)
            TYPE_FILTERED_IRQ: has_noise_filter = 1'b1;
            default: has_noise_filter = 1'b0;
        endcase
    endfunction
endpackage

// ==== verification/port_pin_function_config_test.sv ====
// testbench: register access, pin gating, timer routing and byte port modes
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_config_test;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] kPadIn, kPullEn, kCoreIn, kLevel, kFloat, kPullEnB, caps;
    logic t1a, t1b, t6a, t6b;
    logic [7:0] aPadIn, aPadOut, aPadOe, aPullEn, aCoreIn, aGpOut, extBusLineOut;
    logic [7:0] extBusLineOe, aLevel, aPullEnB;
    int error_cnt = 0;
    int tests_run = 0;

    assign caps = {t6b, t6a, t1b, t1a};

    ppf_pin_cfg u_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .kPadIn(kPadIn), .kPullEn(kPullEn),
        .kCoreIn(kCoreIn), .timerOneCaptureA(t1a), .timerOneCaptureB(t1b),
        .timerSixCaptureA(t6a), .timerSixCaptureB(t6b), .aPadIn(aPadIn),
        .aPadOut(aPadOut), .aPadOe(aPadOe), .aPullEn(aPullEn), .aCoreIn(aCoreIn),
        .aGpOut(aGpOut), .extBusLineOut(extBusLineOut), .extBusLineOe(extBusLineOe));

    // second copy with the pin types whose pulls are forced on in reset
    ppf_pin_cfg #(.K_TYPE(ppf_pkg::TYPE_BIDIR_PULLBOTH), .A_TYPE(ppf_pkg::TYPE_OUTPUT_ONLY))
    u_dut_pull (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .kPadIn(kPadIn), .kPullEn(kPullEnB),
        .kCoreIn(), .timerOneCaptureA(), .timerOneCaptureB(),
        .timerSixCaptureA(), .timerSixCaptureB(), .aPadIn(aPadIn),
        .aPadOut(), .aPadOe(), .aPullEn(aPullEnB), .aCoreIn(),
        .aGpOut(aGpOut), .extBusLineOut(extBusLineOut), .extBusLineOe(extBusLineOe));

    ppf_pin_partner u_pins (.mclk(mclk), .kLevel(kLevel), .kFloat(kFloat),
        .kPullEn(kPullEn), .aLevel(aLevel), .aPadOut(aPadOut), .aPadOe(aPadOe),
        .aPullEn(aPullEn), .kPadIn(kPadIn), .aPadIn(aPadIn));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'h2, 32'(n));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask

    task automatic forced_pulls;
        chk("kPullEn in reset", 32'h0, {28'h0, kPullEn});
        chk("aPullEn in reset", 32'h0, {24'h0, aPullEn});
        chk("kPullEn forced", 32'hf, {28'h0, kPullEnB});
        chk("aPullEn forced", 32'hff, {24'h0, aPullEnB});
    endtask

    task automatic t_regs;
        rdchk("timer sel reset", ppf_pkg::OFF_TIMER_INPUT_SELECT, 32'h0);
        rdchk("pullup reset", ppf_pkg::OFF_PULLUP_CONTROL, 32'h0);
        rdchk("gate reset", ppf_pkg::OFF_INPUT_GATE_CONTROL, 32'h0);
        rdchk("byte ctrl reset", ppf_pkg::OFF_BYTE_PORT_OUTPUT_CTRL, 32'h0);
        apb(1'b1, ppf_pkg::OFF_PULLUP_CONTROL, 32'hffff_fff0);
        settle();
        chk("kPullEn upper write", 32'h0, {28'h0, kPullEn});
        rdchk("pullup upper", ppf_pkg::OFF_PULLUP_CONTROL, 32'h0);
        apb(1'b1, ppf_pkg::OFF_INPUT_GATE_CONTROL, 32'hffff_ffff);
        rdchk("gate field", ppf_pkg::OFF_INPUT_GATE_CONTROL, 32'hf);
        apb(1'b1, ppf_pkg::OFF_TIMER_INPUT_SELECT, 32'hffff_ffff);
        rdchk("timer sel field", ppf_pkg::OFF_TIMER_INPUT_SELECT, 32'hf);
        apb(1'b1, 12'h014, 32'hffff_ffff);
        chk("unmapped err", 32'h1, {31'h0, err});
        rdchk("unmapped data", 12'h014, 32'h0);
    endtask

    task automatic t_pins;
        kLevel <= 4'hb;
        apb(1'b1, ppf_pkg::OFF_PULLUP_CONTROL, 32'h9);
        apb(1'b1, ppf_pkg::OFF_INPUT_GATE_CONTROL, 32'h6);
        settle();
        chk("kPullEn", 32'h9, {28'h0, kPullEn});
        chk("kCoreIn gated", 32'h2, {28'h0, kCoreIn});
        chk("captures all", 32'h2, {28'h0, caps});
        apb(1'b1, ppf_pkg::OFF_TIMER_INPUT_SELECT, 32'h5);
        apb(1'b1, ppf_pkg::OFF_INPUT_GATE_CONTROL, 32'hf);
        settle();
        chk("kCoreIn open", 32'hb, {28'h0, kCoreIn});
        chk("captures some", 32'h1, {28'h0, caps});
        // pins 0 and 3 float: only their pull-ups make them read high
        kLevel <= 4'h2;
        kFloat <= 4'h9;
        settle();
        chk("kCoreIn pulled", 32'hb, {28'h0, kCoreIn});
    endtask

    task automatic t_byte;
        aLevel <= 8'h3c;
        aGpOut <= 8'ha5;
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_INPUT_GATE, 32'hff);
        settle();
        chk("input oe", 32'h0, {24'h0, aPadOe});
        chk("input core", 32'h3c, {24'h0, aCoreIn});
        rdchk("pin status", ppf_pkg::OFF_PIN_LEVEL_STATUS, 32'h3cb);
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_OPEN_DRAIN, 32'hff);
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_INPUT_GATE, 32'h0);
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_OUTPUT_CTRL, 32'hff);
        settle();
        chk("output oe", 32'hff, {24'h0, aPadOe});
        chk("output data", 32'ha5, {24'h0, aPadOut});
        chk("output core", 32'h0, {24'h0, aCoreIn});
        extBusLineOut <= 8'h5a;
        extBusLineOe <= 8'h0f;
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_OPEN_DRAIN, 32'h0);
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_FUNC_SELECT, 32'hff);
        rdchk("func sel", ppf_pkg::OFF_BYTE_PORT_FUNC_SELECT, 32'hff);
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_INPUT_GATE, 32'hff);
        settle();
        chk("bus oe", 32'h0f, {24'h0, aPadOe});
        chk("bus data", 32'h5a, {24'h0, aPadOut});
        chk("bus core", 32'h3a, {24'h0, aCoreIn});
        apb(1'b1, ppf_pkg::OFF_BYTE_PORT_PULLUP, 32'hff);
        settle();
        chk("aPullEn", 32'hff, {24'h0, aPullEn});
        chk("bus core pulled", 32'hfa, {24'h0, aCoreIn});
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        forced_pulls();
        rst <= 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        kLevel = 4'h0;
        kFloat = 4'h0;
        aLevel = 8'h00;
        aGpOut = 8'h00;
        extBusLineOut = 8'h00;
        extBusLineOe = 8'h00;
        repeat (6) @(posedge mclk);
        forced_pulls();
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_byte();
        settle();
        rdchk("pullup after reset", ppf_pkg::OFF_PULLUP_CONTROL, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire

// ==== verification/ppf_pin_partner.sv ====
// partner model: pins of both ports as the outside world and the pulls present them
`timescale 1ns/1ps
`default_nettype none
module ppf_pin_partner (
    input wire logic mclk,
    input wire logic [3:0] kLevel,
    input wire logic [3:0] kFloat,
    input wire logic [3:0] kPullEn,
    input wire logic [7:0] aLevel,
    input wire logic [7:0] aPadOut,
    input wire logic [7:0] aPadOe,
    input wire logic [7:0] aPullEn,
    output logic [3:0] kPadIn,
    output logic [7:0] aPadIn
);
    logic wander;

    // an unpulled floating pin wanders, so no stale level can be relied on
    initial wander = 1'b0;
    always @(posedge mclk) begin
        wander <= ~wander;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            kPadIn[i] = kFloat[i] ? (kPullEn[i] | wander) : kLevel[i];
        end
        for (int i = 0; i < 8; i++) begin
            aPadIn[i] = aPadOe[i] ? aPadOut[i] : (aPullEn[i] | aLevel[i]);
        end
    end
endmodule
`default_nettype wire
